// ===== fie_pkg.sv
// Package for the fault interrupt enable bank: offsets, field layout, codes and reset values
package fie_pkg;

  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 16;
  localparam int          NSRC            = 7;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0]  SUPPLY_EN_OFS   = 8'h08;
  localparam logic [7:0]  CONV_EN_OFS     = 8'h0A;
  localparam logic [7:0]  GLOBAL_EN_OFS   = 8'h0C;
  localparam logic [7:0]  SUPPLY_STAT_OFS = 8'h0E;
  localparam logic [7:0]  CONV_STAT_OFS   = 8'h10;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [15:0] SUPPLY_EN_RST   = 16'h2AAA;
  localparam logic [15:0] CONV_EN_RST     = 16'hA028;
  localparam logic        GLOBAL_EN_RST   = 1'b1;

  // ****************************************
  // Field layout: source i of the supply bank sits in field i,
  // source i of the converter bank sits in field i + CONV_FIELD_BASE
  // ****************************************
  localparam int          FIELD_W         = 2;
  localparam int          SUPPLY_FIELD_BASE = 0;
  localparam int          CONV_FIELD_BASE = 1;
  localparam int          GLOBAL_FIELD    = 3;

  // Supply bank source order, fields 0..6
  localparam int          SRC_INPUT_UV    = 0;
  localparam int          SRC_INPUT_OV    = 1;
  localparam int          SRC_LOGIC_UV    = 2;
  localparam int          SRC_INPUT_OC    = 3;
  localparam int          SRC_PUMP_CAP    = 4;
  localparam int          SRC_PUMP_FAULT  = 5;
  localparam int          SRC_SYNC_LOSS   = 6;
  // Converter bank source order, fields 1..7
  localparam int          SRC_CONV_OV     = 0;
  localparam int          SRC_CONV_OC     = 1;
  localparam int          SRC_FREQ_RES    = 2;
  localparam int          SRC_MODE_RES    = 3;
  localparam int          SRC_STRING_RES  = 4;
  localparam int          SRC_CURR_RES    = 5;
  localparam int          SRC_OVERTEMP    = 6;

  // ****************************************
  // Keyed codes
  // ****************************************
  localparam logic [1:0]  CODE_DISABLE    = 2'h1;
  localparam logic [1:0]  CODE_ENABLE     = 2'h3;
  localparam logic [1:0]  READ_DISABLED   = 2'h0;
  localparam logic [1:0]  READ_ENABLED    = 2'h2;

endpackage : fie_pkg

// ===== fie_enable_bank.sv
// Fault interrupt enable bank with keyed enable fields, latched fault status and interrupt output
// Behaviour
// (RL1) Write 3h enables, 1h disables a source
// (RL2) Field reads 2h enabled, 0h disabled
// (RL3) Supply enables at 08h, reset 2AAAh
// (RL4) Sync loss enable bits 13-12, enabled
// (RL5) Pump fault enable bits 11-10, enabled
// (RL6) Pump capacitor enable bits 9-8, enabled
// (RL7) Input overcurrent enable bits 7-6, enabled
// (RL8) Logic supply low enable bits 5-4, enabled
// (RL9) Input overvoltage enable bits 3-2, enabled
// (RL10) Input undervoltage enable bits 1-0, enabled
// (RL11) Converter enables at 0Ah, reset A028h
// (RL12) Overtemperature enable bits 15-14, enabled
// (RL13) Current resistor short bits 13-12, enabled
// (RL14) String resistor missing bits 11-10, disabled
// (RL15) Mode resistor missing bits 9-8, disabled
// (RL16) Frequency resistor missing bits 7-6, disabled
// (RL17) Converter overcurrent bits 5-4, enabled
// (RL18) Converter overvoltage bits 3-2, enabled
// (RL19) Reserved bits read zero, control nothing
// (RL20) Clear needs status and clear both written
// (RL21) Global enable field uses same codes
// (RL22) Interrupt needs status, source and global enable
// (RL23) Codes 0h and 2h change nothing
module fie_enable_bank (
  input  wire logic                  sys_clk,
  input  wire logic                  reset,
  input  wire logic [7:0]            reg_addr,
  input  wire logic [15:0]           reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [15:0]           reg_rdata,
  output logic                       reg_rvalid,
  input  wire logic [6:0]            supply_fault_evt,
  input  wire logic [6:0]            conv_fault_evt,
  output logic                       fault_irq
);

  logic [6:0] sup_en_r;
  logic [6:0] cnv_en_r;
  logic       glob_en_r;
  logic [6:0] sup_stat_r;
  logic [6:0] cnv_stat_r;
  logic       wr_sup_en;
  logic       wr_cnv_en;
  logic       wr_glob;
  logic       wr_sup_st;
  logic       wr_cnv_st;
  logic [15:0] rd_nxt;
  logic       irq_nxt;

  // ****************************************
  // Helper functions
  // ****************************************
  // Keyed update: only the two codes move the state, so a stray write of 0h or 2h
  // (for example a read-modify-write of the read value) leaves the source alone
  function automatic logic key_apply(input logic cur, input logic [1:0] code);
    logic res;
    res = cur;
    unique case (code)
      fie_pkg::CODE_ENABLE:  res = 1'b1;   // RL1
      fie_pkg::CODE_DISABLE: res = 1'b0;   // RL1
      default:               res = cur;    // RL23
    endcase
    return res;
  endfunction : key_apply

  function automatic logic [1:0] key_read(input logic en);
    return en ? fie_pkg::READ_ENABLED : fie_pkg::READ_DISABLED;  // RL2
  endfunction : key_read

  function automatic logic [1:0] field_of(input logic [15:0] w, input int idx);
    return w[idx*fie_pkg::FIELD_W +: fie_pkg::FIELD_W];
  endfunction : field_of

  // Reset state of a source comes from its read code in the reset word
  function automatic logic rst_bit(input logic [15:0] w, input int idx);
    return field_of(w, idx) == fie_pkg::READ_ENABLED;
  endfunction : rst_bit

  // ****************************************
  // Address decode
  // ****************************************
  assign wr_sup_en = reg_wr && (reg_addr == fie_pkg::SUPPLY_EN_OFS);    // RL3
  assign wr_cnv_en = reg_wr && (reg_addr == fie_pkg::CONV_EN_OFS);      // RL11
  assign wr_glob   = reg_wr && (reg_addr == fie_pkg::GLOBAL_EN_OFS);
  assign wr_sup_st = reg_wr && (reg_addr == fie_pkg::SUPPLY_STAT_OFS);
  assign wr_cnv_st = reg_wr && (reg_addr == fie_pkg::CONV_STAT_OFS);

  // ****************************************
  // Enable registers
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      for (int i = 0; i < fie_pkg::NSRC; i++) begin
        sup_en_r[i] <= rst_bit(fie_pkg::SUPPLY_EN_RST, i + fie_pkg::SUPPLY_FIELD_BASE);  // RL3
      end
    end else if (wr_sup_en) begin
      // Field i carries source i, in the source order of the package
      for (int i = 0; i < fie_pkg::NSRC; i++) begin  // RL5 RL6 RL7 RL8 RL9 RL10
        sup_en_r[i] <= key_apply(sup_en_r[i], field_of(reg_wdata, i + fie_pkg::SUPPLY_FIELD_BASE)); // RL4
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      for (int i = 0; i < fie_pkg::NSRC; i++) begin
        cnv_en_r[i] <= rst_bit(fie_pkg::CONV_EN_RST, i + fie_pkg::CONV_FIELD_BASE);  // RL11
      end
    end else if (wr_cnv_en) begin
      // Field 0 is reserved and skipped
      for (int i = 0; i < fie_pkg::NSRC; i++) begin  // RL13 RL14 RL15 RL16 RL17 RL18 RL19
        cnv_en_r[i] <= key_apply(cnv_en_r[i], field_of(reg_wdata, i + fie_pkg::CONV_FIELD_BASE)); // RL12
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      glob_en_r <= fie_pkg::GLOBAL_EN_RST;
    end else if (wr_glob) begin
      glob_en_r <= key_apply(glob_en_r, field_of(reg_wdata, fie_pkg::GLOBAL_FIELD));  // RL21
    end
  end

  // ****************************************
  // Fault status latches
  // ****************************************
  // Status bit at odd position, its clear partner just below; a new event wins over a clear
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sup_stat_r <= '0;
    end else begin
      for (int i = 0; i < fie_pkg::NSRC; i++) begin
        if (supply_fault_evt[i]) begin
          sup_stat_r[i] <= 1'b1;
        end else if (wr_sup_st && (field_of(reg_wdata, i) == 2'h3)) begin
          sup_stat_r[i] <= 1'b0;  // RL20
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cnv_stat_r <= '0;
    end else begin
      for (int i = 0; i < fie_pkg::NSRC; i++) begin
        if (conv_fault_evt[i]) begin
          cnv_stat_r[i] <= 1'b1;
        end else if (wr_cnv_st && (field_of(reg_wdata, i + fie_pkg::CONV_FIELD_BASE) == 2'h3)) begin
          cnv_stat_r[i] <= 1'b0;  // RL20
        end
      end
    end
  end

  // ****************************************
  // Interrupt output
  // ****************************************
  assign irq_nxt = glob_en_r && (|(sup_stat_r & sup_en_r) || |(cnv_stat_r & cnv_en_r));  // RL22

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      fault_irq <= 1'b0;
    end else begin
      fault_irq <= irq_nxt;
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  // Reserved fields and unmapped offsets read zero
  always_comb begin
    rd_nxt = '0;
    unique case (reg_addr)
      fie_pkg::SUPPLY_EN_OFS: begin
        for (int i = 0; i < fie_pkg::NSRC; i++) begin
          rd_nxt[2*(i + fie_pkg::SUPPLY_FIELD_BASE) +: 2] = key_read(sup_en_r[i]);  // RL2
        end
      end
      fie_pkg::CONV_EN_OFS: begin
        for (int i = 0; i < fie_pkg::NSRC; i++) begin
          rd_nxt[2*(i + fie_pkg::CONV_FIELD_BASE) +: 2] = key_read(cnv_en_r[i]);  // RL19
        end
      end
      fie_pkg::GLOBAL_EN_OFS: rd_nxt[2*fie_pkg::GLOBAL_FIELD +: 2] = key_read(glob_en_r);
      fie_pkg::SUPPLY_STAT_OFS: begin
        for (int i = 0; i < fie_pkg::NSRC; i++) begin
          rd_nxt[2*i + 1] = sup_stat_r[i];
        end
      end
      fie_pkg::CONV_STAT_OFS: begin
        for (int i = 0; i < fie_pkg::NSRC; i++) begin
          rd_nxt[2*(i + fie_pkg::CONV_FIELD_BASE) + 1] = cnv_stat_r[i];
        end
      end
      default: rd_nxt = '0;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      reg_rdata  <= '0;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rdata  <= reg_rd ? rd_nxt : 16'h0000;
      reg_rvalid <= reg_rd;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  enable_code_a: assert property (wr_sup_en && reg_wdata[13:12] == 2'h3 |=> sup_en_r[6])  // RL1
    else $error("enable code did not enable sync loss");
  disable_code_a: assert property (wr_cnv_en && reg_wdata[15:14] == 2'h1 |=> !cnv_en_r[6])  // RL1
    else $error("disable code did not disable overtemperature");
  neutral_code_a: assert property (wr_sup_en && reg_wdata[1:0] inside {2'h0, 2'h2}
                                   |=> $stable(sup_en_r[0]))  // RL23
    else $error("neutral code changed undervoltage enable");
  read_code_a: assert property (reg_rd && reg_addr == 8'h08  // RL2
                                |=> reg_rvalid && reg_rdata[13:12] == ($past(sup_en_r[6]) ? 2'h2 : 2'h0)
                                    && reg_rdata[15:14] == 2'h0)
    else $error("supply enable read code wrong");
  conv_reserved_a: assert property (reg_rd && reg_addr == 8'h0A |=> reg_rdata[1:0] == 2'h0)  // RL19
    else $error("converter reserved field not zero");
  global_code_a: assert property (wr_glob && reg_wdata[7:6] == 2'h1 |=> !glob_en_r ##1 !fault_irq)  // RL21
    else $error("global disable not honoured");
  irq_cause_a: assert property (supply_fault_evt[3] && sup_en_r[3] && glob_en_r && !wr_glob && !wr_sup_en  // RL22
                                |=> ##1 fault_irq)
    else $error("interrupt missing after enabled fault");
  clear_pair_a: assert property (wr_sup_st && reg_wdata[7:6] == 2'h2 && sup_stat_r[3]
                                 |=> sup_stat_r[3])  // RL20
    else $error("status cleared without clear bit");
  set_wins_a: assert property (wr_cnv_st && reg_wdata[3:2] == 2'h3 && conv_fault_evt[0]
                               |=> cnv_stat_r[0])  // RL20
    else $error("event lost under clear");
  reset_value_a: assert property ($fell(reset) |-> sup_en_r == 7'h7F && cnv_en_r == 7'h63)  // RL11
    else $error("enable reset values wrong");
  rvalid_a: assert property (reg_rd |=> reg_rvalid)  // RL2
    else $error("read answer missing");
  rdata_idle_a: assert property (!reg_rd |=> !reg_rvalid && reg_rdata == 16'h0000)  // RL2
    else $error("read data not idle");
  conv_read_a: assert property (reg_rd && reg_addr == 8'h0A  // RL2
                                |=> reg_rdata[15:14] == ($past(cnv_en_r[6]) ? 2'h2 : 2'h0))
    else $error("converter enable read code wrong");
  global_read_a: assert property (reg_rd && reg_addr == 8'h0C  // RL21
                                  |=> reg_rdata == ($past(glob_en_r) ? 16'h0080 : 16'h0000))
    else $error("global enable read code wrong");
  irq_quiet_a: assert property (!glob_en_r |=> !fault_irq)  // RL22
    else $error("interrupt with global enable off");
  no_cause_a: assert property (!(|(sup_stat_r & sup_en_r)) && !(|(cnv_stat_r & cnv_en_r))  // RL22
                               |=> !fault_irq)
    else $error("interrupt without enabled fault");

  // ****************************************
  // Field placement: each code must reach its own source
  // ****************************************
  sync_loss_a: assert property (wr_sup_en && reg_wdata[13:12] == 2'h1  // RL4
                                |=> !sup_en_r[fie_pkg::SRC_SYNC_LOSS])
    else $error("disable code missed sync loss");
  pump_fault_a: assert property (wr_sup_en && reg_wdata[11:10] == 2'h1  // RL5
                                 |=> !sup_en_r[fie_pkg::SRC_PUMP_FAULT])
    else $error("disable code missed pump fault");
  pump_cap_a: assert property (wr_sup_en && reg_wdata[9:8] == 2'h1  // RL6
                               |=> !sup_en_r[fie_pkg::SRC_PUMP_CAP])
    else $error("disable code missed pump capacitor");
  input_oc_a: assert property (wr_sup_en && reg_wdata[7:6] == 2'h1  // RL7
                               |=> !sup_en_r[fie_pkg::SRC_INPUT_OC])
    else $error("disable code missed input overcurrent");
  logic_uv_a: assert property (wr_sup_en && reg_wdata[5:4] == 2'h1  // RL8
                               |=> !sup_en_r[fie_pkg::SRC_LOGIC_UV])
    else $error("disable code missed logic supply low");
  input_ov_a: assert property (wr_sup_en && reg_wdata[3:2] == 2'h1  // RL9
                               |=> !sup_en_r[fie_pkg::SRC_INPUT_OV])
    else $error("disable code missed input overvoltage");
  input_uv_a: assert property (wr_sup_en && reg_wdata[1:0] == 2'h1  // RL10
                               |=> !sup_en_r[fie_pkg::SRC_INPUT_UV])
    else $error("disable code missed input undervoltage");
  overtemp_on_a: assert property (wr_cnv_en && reg_wdata[15:14] == 2'h3  // RL12
                                  |=> cnv_en_r[fie_pkg::SRC_OVERTEMP])
    else $error("enable code missed overtemperature");
  curr_res_a: assert property (wr_cnv_en && reg_wdata[13:12] == 2'h3  // RL13
                               |=> cnv_en_r[fie_pkg::SRC_CURR_RES])
    else $error("enable code missed current resistor");
  string_res_a: assert property (wr_cnv_en && reg_wdata[11:10] == 2'h3  // RL14
                                 |=> cnv_en_r[fie_pkg::SRC_STRING_RES])
    else $error("enable code missed string resistor");
  mode_res_a: assert property (wr_cnv_en && reg_wdata[9:8] == 2'h3  // RL15
                               |=> cnv_en_r[fie_pkg::SRC_MODE_RES])
    else $error("enable code missed mode resistor");
  freq_res_a: assert property (wr_cnv_en && reg_wdata[7:6] == 2'h3  // RL16
                               |=> cnv_en_r[fie_pkg::SRC_FREQ_RES])
    else $error("enable code missed frequency resistor");
  conv_oc_a: assert property (wr_cnv_en && reg_wdata[5:4] == 2'h3  // RL17
                              |=> cnv_en_r[fie_pkg::SRC_CONV_OC])
    else $error("enable code missed converter overcurrent");
  conv_ov_a: assert property (wr_cnv_en && reg_wdata[3:2] == 2'h3  // RL18
                              |=> cnv_en_r[fie_pkg::SRC_CONV_OV])
    else $error("enable code missed converter overvoltage");

  irq_raised_c:  cover property (!fault_irq ##1 fault_irq);
  irq_cleared_c: cover property (fault_irq ##1 !fault_irq);
  reenable_c:    cover property (wr_cnv_en && reg_wdata[11:10] == 2'h3 ##1 cnv_en_r[4]);
  neutral_c:     cover property (wr_sup_en && reg_wdata == 16'h2AAA);
  clear_c:       cover property (wr_sup_st && reg_wdata[7:6] == 2'h3 && sup_stat_r[3]);

endmodule : fie_enable_bank

// ===== fie_host_model.sv
// Host controller model that reaches the enable bank through its register strobes
module fie_host_model (
  input  wire logic        sys_clk,
  output logic      [7:0]  reg_addr,
  output logic      [15:0] reg_wdata,
  output logic             reg_wr,
  output logic             reg_rd,
  input  wire logic [15:0] reg_rdata,
  input  wire logic        reg_rvalid
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 16'h0000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  // ****************************************
  // Register cycles
  // ****************************************
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
    // Stale data must never be mistaken for a fresh write
    reg_wdata <= ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    // The answer stands for the one cycle after the strobe is taken
    @(posedge sys_clk);
    v = reg_rvalid;
    d = reg_rdata;
  endtask : rd
endmodule : fie_host_model

// ===== fault_interrupt_enable_bank_tb.sv
// Self-checking bench for the fault interrupt enable bank
module fault_interrupt_enable_bank_tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic        sys_clk = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic        reg_rvalid;
  logic [6:0]  supply_fault_evt = 7'h00;
  logic [6:0]  conv_fault_evt = 7'h00;
  logic        fault_irq;
  int          failures;
  int          comparisons;
  int          cycles;
  logic        en [14];
  logic        glob;
  logic [7:0]  ofs [4] = '{8'h08, 8'h0A, 8'h0C, 8'h02};

  always #50 sys_clk = ~sys_clk;

  fie_enable_bank i_fie_enable_bank (
    .sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .supply_fault_evt(supply_fault_evt), .conv_fault_evt(conv_fault_evt), .fault_irq(fault_irq));

  fie_host_model i_fie_host_model (
    .sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

  // ****************************************
  // Reference model and helpers
  // ****************************************
  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  function automatic logic nxt(logic cur, logic [1:0] c);
    return (c == 2'h3) ? 1'b1 : ((c == 2'h1) ? 1'b0 : cur);
  endfunction : nxt

  function automatic logic [15:0] exp_rd(logic [7:0] a);
    logic [15:0] r;
    r = 16'h0000;
    for (int i = 0; i < 7; i++) begin
      if (a == fie_pkg::SUPPLY_EN_OFS) r[2*i+1] = en[i];
      if (a == fie_pkg::CONV_EN_OFS) r[2*i+3] = en[i+7];
    end
    if (a == fie_pkg::GLOBAL_EN_OFS) r[7] = glob;
    return r;
  endfunction : exp_rd

  task automatic wr_model(logic [7:0] a, logic [15:0] d);
    i_fie_host_model.wr(a, d);
    for (int i = 0; i < 7; i++) begin
      if (a == fie_pkg::SUPPLY_EN_OFS) en[i] = nxt(en[i], d[2*i+:2]);
      if (a == fie_pkg::CONV_EN_OFS) en[i+7] = nxt(en[i+7], d[2*i+2+:2]);
    end
    if (a == fie_pkg::GLOBAL_EN_OFS) glob = nxt(glob, d[7:6]);
  endtask : wr_model

  task automatic rd_check(logic [7:0] a);
    logic [15:0] d;
    logic        v;
    i_fie_host_model.rd(a, d, v);
    check("reg_rvalid", {15'h0000, v}, 16'h0001);
    check("reg_rdata", d, exp_rd(a));
  endtask : rd_check

  task automatic finish_test();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : finish_test

  // A hang is cut off well past the expected run of about 750 cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      finish_test();
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    int f;
    logic [7:0] sa;
    logic [15:0] rd_d;
    logic        rd_v;
    void'($urandom(32'hABCB));
    for (int i = 0; i < 7; i++) begin
      en[i]   = fie_pkg::SUPPLY_EN_RST[2*i+1];
      en[i+7] = fie_pkg::CONV_EN_RST[2*i+3];
    end
    glob = fie_pkg::GLOBAL_EN_RST;
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    for (int i = 0; i < 4; i++) rd_check(ofs[i]);
    check("fault_irq", {15'h0000, fault_irq}, 16'h0000);
    // Random codes in every field, unmapped offset included
    for (int n = 0; n < 60; n++) begin
      f = $urandom_range(3);
      wr_model(ofs[f], 16'($urandom));
      rd_check(ofs[f]);
    end
    for (int g = 0; g < 2; g++) begin
      wr_model(fie_pkg::GLOBAL_EN_OFS, g ? 16'h0040 : 16'h00C0);
      for (int s = 0; s < 14; s++) begin
        f  = (s < 7) ? s : s - 6;
        sa = (s < 7) ? fie_pkg::SUPPLY_STAT_OFS : fie_pkg::CONV_STAT_OFS;
        @(posedge sys_clk);
        if (s < 7) supply_fault_evt <= 7'(1 << s);
        else conv_fault_evt <= 7'(1 << (s - 7));
        @(posedge sys_clk);
        supply_fault_evt <= 7'h00;
        conv_fault_evt   <= 7'h00;
        @(posedge sys_clk);
        #1;
        check("fault_irq", {15'h0000, fault_irq}, {15'h0000, en[s] & glob});
        i_fie_host_model.rd(sa, rd_d, rd_v);
        check("status", rd_v ? rd_d : 16'hFFFF, 16'(2 << (2 * f)));
        // Status bit alone or clear bit alone must leave the fault latched
        i_fie_host_model.wr(sa, 16'((1 + s % 2) << (2 * f)));
        @(posedge sys_clk);
        #1;
        check("fault_irq", {15'h0000, fault_irq}, {15'h0000, en[s] & glob});
        i_fie_host_model.wr(sa, 16'(3 << (2 * f)));
        @(posedge sys_clk);
        #1;
        check("fault_irq", {15'h0000, fault_irq}, 16'h0000);
        i_fie_host_model.rd(sa, rd_d, rd_v);
        check("status", rd_v ? rd_d : 16'hFFFF, 16'h0000);
      end
    end
    // A clear taken in the same cycle as a new event must lose
    fork
      i_fie_host_model.wr(fie_pkg::CONV_STAT_OFS, 16'h000C);
      begin
        @(posedge sys_clk);
        conv_fault_evt <= 7'h01;
        @(posedge sys_clk);
        conv_fault_evt <= 7'h00;
      end
    join
    i_fie_host_model.rd(fie_pkg::CONV_STAT_OFS, rd_d, rd_v);
    check("status", rd_v ? rd_d : 16'hFFFF, 16'h0008);
    i_fie_host_model.wr(fie_pkg::CONV_STAT_OFS, 16'h000C);
    i_fie_host_model.rd(fie_pkg::CONV_STAT_OFS, rd_d, rd_v);
    check("status", rd_v ? rd_d : 16'hFFFF, 16'h0000);
    finish_test();
  end
endmodule : fault_interrupt_enable_bank_tb
